/* verilog/sbc_pkg.sv */
/*
 * Shared constants and carrier types for the branch sequencer: register
 * offsets, field positions, reset values, state codes and instruction
 * layout. Assumes a 32-bit APB register bus and a 32-bit instruction
 * memory port.
 */
package sbc_pkg;
   // Register byte offsets
   localparam logic [7:0] SBC_OFS_IP = 8'h00;      // Instruction pointer
   localparam logic [7:0] SBC_OFS_SAVED = 8'h04;   // Saved pointer
   localparam logic [7:0] SBC_OFS_NEXT = 8'h08;    // next_address_reg
   localparam logic [7:0] SBC_OFS_STAT = 8'h0c;    // Sequencer status
   localparam logic [7:0] SBC_OFS_LOOP = 8'h10;    // loopback_ctrl_reg
   localparam logic [7:0] SBC_OFS_OCL = 8'h14;     // output_control_latch
   localparam logic [7:0] SBC_OFS_CTL0 = 8'h18;    // bus_ctrl_reg_zero
   localparam logic [7:0] SBC_OFS_BCL = 8'h1c;     // Control lines view
   localparam logic [7:0] SBC_OFS_BDL = 8'h20;     // Data lines view
   // Status bits
   localparam int SBC_ST_HALT = 0;                 // Sequencer halted
   localparam int SBC_ST_INT = 1;                  // Interrupt instruction
   localparam int SBC_ST_ILL = 2;                  // Illegal instruction
   localparam int SBC_ST_RUN = 3;                  // Sequencer running
   // Control bit positions
   localparam int SBC_LOOP_EN = 0;                 // Loopback enable
   localparam int SBC_CTL0_TGT = 0;                // Target mode
   // Output latch and line view bit positions
   localparam int SBC_SIG_IO = 0;
   localparam int SBC_SIG_CD = 1;
   localparam int SBC_SIG_MSG = 2;
   localparam int SBC_SIG_ATN = 3;
   localparam int SBC_SIG_SEL = 4;
   localparam int SBC_SIG_BSY = 5;
   localparam int SBC_SIG_ACK = 6;
   localparam int SBC_SIG_REQ = 7;
   // First instruction word layout
   localparam int SBC_F_TYPE = 30;                 // Two-bit class, low bit
   localparam int SBC_F_OPC = 27;                  // Three-bit opcode, low bit
   localparam int SBC_F_PHASE = 24;                // Three-bit phase, low bit
   localparam int SBC_F_TRUE = 19;                 // Jump if true
   localparam int SBC_F_CDATA = 18;                // Compare data
   localparam int SBC_F_CPHASE = 17;               // Compare phase
   localparam int SBC_F_WAIT = 16;                 // Wait for valid phase
   localparam logic [1:0] SBC_TYPE_XFER = 2'h2;    // Transfer control class
   // Opcodes
   localparam logic [2:0] SBC_OP_JUMP = 3'h0;
   localparam logic [2:0] SBC_OP_CALL = 3'h1;
   localparam logic [2:0] SBC_OP_RET = 3'h2;
   localparam logic [2:0] SBC_OP_INT = 3'h3;
   // Phase codes, bit order MSG, C/D, I/O
   localparam logic [2:0] SBC_PH_DOUT = 3'h0;
   localparam logic [2:0] SBC_PH_DIN = 3'h1;
   localparam logic [2:0] SBC_PH_CMD = 3'h2;
   localparam logic [2:0] SBC_PH_STAT = 3'h3;
   localparam logic [2:0] SBC_PH_MOUT = 3'h6;
   localparam logic [2:0] SBC_PH_MIN = 3'h7;
   // Pointer steps and reset values
   localparam logic [31:0] SBC_WORD_STEP = 32'h4;  // One word fetched
   localparam logic [31:0] SBC_IP_RST = 32'h0;
   localparam logic [7:0] SBC_OCL_RST = 8'h0;
   // Sequencer states, one-hot
   typedef enum logic [5:0] {
      SBC_S_IDLE = 6'b000001,
      SBC_S_F0 = 6'b000010,
      SBC_S_F1 = 6'b000100,
      SBC_S_EXEC = 6'b001000,
      SBC_S_WAIT = 6'b010000,
      SBC_S_HALT = 6'b100000
   } sbc_state_t;
   // Decoded compare fields
   typedef struct packed {
      logic [2:0] phase;
      logic jump_true;
      logic cmp_data;
      logic cmp_phase;
      logic [7:0] data;
   } sbc_cond_t;
   // Live bus lines seen by the sequencer
   typedef struct packed {
      logic [2:0] phase;
      logic req;
      logic atn;
      logic sel;
      logic bsy;
      logic ack;
      logic [7:0] data;
   } sbc_bus_t;
endpackage : sbc_pkg

/* verilog/sbc_cond_eval.sv */
/*
 * Condition evaluator: latches phase and first data byte at each REQ
 * assertion and reports the branch decision. Assumes bus lines are
 * synchronous to mclk.
 */
`timescale 1ns/1ps
module sbc_cond_eval (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Bus and mode
   input sbc_pkg::sbc_bus_t bus,
   input wire logic target_mode,
   // Instruction condition
   input sbc_pkg::sbc_cond_t cond,
   // Results
   output logic req_evt,
   output logic taken
);
   import sbc_pkg::*;
   logic req_d_r;      // REQ one cycle ago
   logic [2:0] ph_r;   // Phase latched at REQ
   logic [7:0] byte_r; // First byte received
   logic evt_r;        // New REQ seen
   logic ph_hit;       // Phase comparison
   logic dt_hit;       // Data comparison

   // Latch phase and data on REQ assertion
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         req_d_r <= 1'b0;
         ph_r <= 3'h0;
         byte_r <= 8'h0;
         evt_r <= 1'b0;
      end else begin
         req_d_r <= bus.req;
         evt_r <= bus.req && !req_d_r;
         if (bus.req && !req_d_r) begin
            ph_r <= bus.phase;
            byte_r <= bus.data;
         end
      end
   end

   // Compare and apply branch sense
   always_comb begin
      // Target mode turns the phase test into an ATN test
      ph_hit = target_mode ? bus.atn : (ph_r == cond.phase);
      dt_hit = (byte_r == cond.data);
      if (cond.cmp_phase && cond.cmp_data) begin
         taken = cond.jump_true ? (ph_hit && dt_hit)
                                : (!ph_hit && !dt_hit);
      end else if (cond.cmp_phase) begin
         taken = (ph_hit == cond.jump_true);
      end else if (cond.cmp_data) begin
         taken = (dt_hit == cond.jump_true);
      end else begin
         // Nothing enabled: unconditional transfer
         taken = 1'b1;
      end
   end

   assign req_evt = evt_r;

   a_latch_on_req: assert property (
      @(posedge mclk) disable iff (!arst_n)
      bus.req && !req_d_r |=> ph_r == $past(bus.phase))
      else $error("phase not latched at REQ");
   a_both_true: assert property (
      @(posedge mclk) disable iff (!arst_n)
      cond.cmp_phase && cond.cmp_data && cond.jump_true && !dt_hit
      |-> !taken)
      else $error("branch with one compare false");
endmodule : sbc_cond_eval

/* verilog/sbc_sequencer.sv */
/*
 * Branch sequencer top: APB register file, instruction fetch loop,
 * transfer control execution, halt and restart, loopback drive.
 * Assumes a memory that holds address and request until it returns
 * one-cycle mem_ack with data, and bus lines synchronous to mclk.
 */
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module sbc_sequencer (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Instruction memory
   output logic mem_req,
   output logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // Bus lines
   input sbc_pkg::sbc_bus_t bus,
   output logic [7:0] scsi_ctl_o,
   output logic [7:0] scsi_ctl_oe,
   // Host interrupt
   output logic irq_n
);
   import sbc_pkg::*;
   sbc_state_t st_r;      // Sequencer state
   sbc_state_t st_nxt;    // Next state
   logic [31:0] ip_r;     // Instruction pointer
   logic [31:0] saved_r;  // Saved pointer for call and return
   logic [31:0] next_r;   // Jump address or interrupt vector
   logic [31:0] w0_r;     // First instruction word
   logic int_r;           // Interrupt instruction flag
   logic ill_r;           // Illegal instruction flag
   logic irq_n_r;         // Interrupt line
   logic loop_r;          // Loopback enable
   logic tgt_r;           // Target mode
   logic [7:0] ocl_r;     // Output control latch
   logic [7:0] ctl_o_r;   // Driven control lines
   logic [7:0] ctl_oe_r;  // Control line enables
   logic mem_req_r;       // Fetch request
   logic pready_r;        // APB answer
   logic pslverr_r;       // APB error
   logic [31:0] prdata_r; // APB read data
   logic acc;             // APB access phase
   logic wr_done;         // Write taking effect
   logic ip_wr;           // Pointer written
   logic stat_wr;         // Status written
   logic mapped;          // Address decodes
   logic [31:0] rd_mux;   // Read value
   logic [2:0] opc;       // Opcode field
   logic legal;           // Legal transfer control
   logic decide;          // Branch decided this cycle
   logic taken;           // Condition met
   logic req_evt;         // New REQ seen
   logic do_int;          // Interrupt instruction fires
   logic do_ill;          // Illegal instruction fires
   sbc_cond_t cond;       // Decoded condition
   logic [7:0] bcl_view;  // Control lines as read
   logic [31:0] fetch_base_r; // Pointer at the first word of a fetch

   // Instruction decode
   assign opc = w0_r[SBC_F_OPC +: 3];
   assign legal = (w0_r[SBC_F_TYPE +: 2] == SBC_TYPE_XFER) && !opc[2];
   assign cond.phase = w0_r[SBC_F_PHASE +: 3];
   assign cond.jump_true = w0_r[SBC_F_TRUE];
   assign cond.cmp_data = w0_r[SBC_F_CDATA];
   assign cond.cmp_phase = w0_r[SBC_F_CPHASE];
   assign cond.data = w0_r[7:0];
   // Decide now, or after the next REQ when waiting for a phase
   assign decide = legal && ((st_r == SBC_S_EXEC && !w0_r[SBC_F_WAIT]) ||
                   (st_r == SBC_S_WAIT && req_evt));
   assign do_int = decide && taken && opc == SBC_OP_INT;
   assign do_ill = st_r == SBC_S_EXEC && !legal;

   sbc_cond_eval u_eval (
      .mclk(mclk),
      .arst_n(arst_n),
      .bus(bus),
      .target_mode(tgt_r),
      .cond(cond),
      .req_evt(req_evt),
      .taken(taken)
   );

   // APB decode; a write lands at the edge that samples pready
   assign acc = psel && penable;
   assign wr_done = acc && pready_r && pwrite && !pslverr_r;
   assign ip_wr = wr_done && paddr == SBC_OFS_IP;
   assign stat_wr = wr_done && paddr == SBC_OFS_STAT;
   assign bcl_view = {bus.req, bus.ack, bus.bsy, bus.sel, bus.atn,
                      bus.phase};

   // Read multiplexer
   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0;
      case (paddr)
         SBC_OFS_IP: rd_mux = ip_r;
         SBC_OFS_SAVED: rd_mux = saved_r;
         SBC_OFS_NEXT: rd_mux = next_r;
         SBC_OFS_STAT: rd_mux = {28'h0, st_r != SBC_S_IDLE &&
                                 st_r != SBC_S_HALT, ill_r, int_r,
                                 st_r == SBC_S_HALT};
         SBC_OFS_LOOP: rd_mux = {31'h0, loop_r};
         SBC_OFS_OCL: rd_mux = {24'h0, ocl_r};
         SBC_OFS_CTL0: rd_mux = {31'h0, tgt_r};
         SBC_OFS_BCL: rd_mux = {24'h0, bcl_view};
         SBC_OFS_BDL: rd_mux = {24'h0, bus.data};
         default: mapped = 1'b0;
      endcase
   end

   // APB answer: one wait cycle, then pready for a single cycle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else if (acc && !pready_r) begin
         pready_r <= 1'b1;
         pslverr_r <= !mapped;
         prdata_r <= pwrite ? 32'h0 : rd_mux;
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   // Software control registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         loop_r <= 1'b0;
         tgt_r <= 1'b0;
         ocl_r <= SBC_OCL_RST;
      end else if (wr_done) begin
         if (paddr == SBC_OFS_LOOP) loop_r <= pwdata[SBC_LOOP_EN];
         if (paddr == SBC_OFS_CTL0) tgt_r <= pwdata[SBC_CTL0_TGT];
         if (paddr == SBC_OFS_OCL) ocl_r <= pwdata[7:0];
      end
   end

   // Loopback: each set latch bit drives its control line high; clear bits leave their line undriven
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_o_r <= 8'h0;
         ctl_oe_r <= 8'h0;
      end else begin
         ctl_o_r <= loop_r ? ocl_r : 8'h0;
         ctl_oe_r <= loop_r ? ocl_r : 8'h0;
      end
   end

   // Next state of the fetch and execute loop
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         SBC_S_IDLE: st_nxt = st_r;
         SBC_S_F0: if (mem_ack) st_nxt = SBC_S_F1;
         SBC_S_F1: if (mem_ack) st_nxt = SBC_S_EXEC;
         SBC_S_EXEC: begin
            if (do_ill) st_nxt = SBC_S_HALT;
            else if (w0_r[SBC_F_WAIT]) st_nxt = SBC_S_WAIT;
            else if (do_int) st_nxt = SBC_S_HALT;
            else st_nxt = SBC_S_F0;
         end
         SBC_S_WAIT: begin
            if (do_int) st_nxt = SBC_S_HALT;
            else if (req_evt) st_nxt = SBC_S_F0;
         end
         SBC_S_HALT: st_nxt = st_r;
         default: st_nxt = SBC_S_IDLE;
      endcase
      // Pointer write starts or restarts fetching
      if (ip_wr) st_nxt = SBC_S_F0;
   end

   // State and fetch request
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= SBC_S_IDLE;
         mem_req_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         mem_req_r <= st_nxt == SBC_S_F0 || st_nxt == SBC_S_F1;
      end
   end

   // Instruction words
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         w0_r <= 32'h0;
         next_r <= 32'h0;
      end else if (mem_ack && st_r == SBC_S_F0) begin
         w0_r <= mem_rdata;
      end else if (mem_ack && st_r == SBC_S_F1) begin
         next_r <= mem_rdata; // Jump address or vector
      end
   end

   // Instruction pointer: four per word, eight per instruction
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ip_r <= SBC_IP_RST;
      end else if (ip_wr) begin
         ip_r <= pwdata;
      end else if (mem_ack && (st_r == SBC_S_F0 || st_r == SBC_S_F1)) begin
         ip_r <= ip_r + SBC_WORD_STEP;
      end else if (decide && taken) begin
         case (opc)
            SBC_OP_JUMP: ip_r <= next_r;
            SBC_OP_CALL: ip_r <= next_r;
            SBC_OP_RET: ip_r <= saved_r;
            default: ip_r <= ip_r;
         endcase
      end
   end

   // Saved pointer for call
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         saved_r <= SBC_IP_RST;
      end else if (decide && taken && opc == SBC_OP_CALL) begin
         saved_r <= ip_r;
      end
   end

   // Interrupt flags and line; a new event wins over a clear
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         int_r <= 1'b0;
         ill_r <= 1'b0;
         irq_n_r <= 1'b1;
      end else begin
         if (do_int) int_r <= 1'b1;
         else if (stat_wr && pwdata[SBC_ST_INT]) int_r <= 1'b0;
         if (do_ill) ill_r <= 1'b1;
         else if (stat_wr && pwdata[SBC_ST_ILL]) ill_r <= 1'b0;
         if (do_int || do_ill) irq_n_r <= 1'b0;
         else if (ip_wr || stat_wr) irq_n_r <= 1'b1;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign mem_req = mem_req_r;
   assign mem_addr = ip_r;
   assign scsi_ctl_o = ctl_o_r;
   assign scsi_ctl_oe = ctl_oe_r;
   assign irq_n = irq_n_r;

   // Pointer at the first word of the fetch under way, for the step check
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         fetch_base_r <= SBC_IP_RST;
      end else if (mem_ack && st_r == SBC_S_F0) begin
         fetch_base_r <= ip_r;
      end
   end

   // End of a fetch: second word acknowledged, then execute
   sequence s_two_words;
      st_r == SBC_S_F1 && mem_ack && !ip_wr ##1 st_r == SBC_S_EXEC;
   endsequence

   a_ip_step_eight: assert property (
      @(posedge mclk) disable iff (!arst_n)
      st_r == SBC_S_F1 && mem_ack && !ip_wr
      |=> ip_r == fetch_base_r + 32'h8)
      else $error("pointer did not advance by eight");
   a_fall_through: assert property (
      @(posedge mclk) disable iff (!arst_n)
      decide && !taken && !ip_wr |=> ip_r == $past(ip_r))
      else $error("untaken branch changed pointer");
   a_jump_load: assert property (
      @(posedge mclk) disable iff (!arst_n)
      decide && taken && opc == SBC_OP_JUMP && !ip_wr
      |=> ip_r == $past(next_r))
      else $error("jump address not loaded");
   a_call_save: assert property (
      @(posedge mclk) disable iff (!arst_n)
      decide && taken && opc == SBC_OP_CALL |=> saved_r == $past(ip_r))
      else $error("call did not save pointer");
   a_int_halts: assert property (
      @(posedge mclk) disable iff (!arst_n)
      do_int && !ip_wr |=> !irq_n && st_r == SBC_S_HALT)
      else $error("interrupt instruction did not halt");
   a_halt_holds: assert property (
      @(posedge mclk) disable iff (!arst_n)
      st_r == SBC_S_HALT && !ip_wr |=> st_r == SBC_S_HALT && !mem_req)
      else $error("halted sequencer resumed on its own");
   a_restart_fetch: assert property (
      @(posedge mclk) disable iff (!arst_n)
      ip_wr |=> st_r == SBC_S_F0 && mem_req && mem_addr == $past(pwdata))
      else $error("pointer write did not restart fetch");
   a_idle_reset: assert property (
      @(posedge mclk) disable iff (!arst_n)
      st_r == SBC_S_IDLE && !ip_wr |=> !mem_req)
      else $error("fetch without pointer write");
   a_illegal_op: assert property (
      @(posedge mclk) disable iff (!arst_n)
      st_r == SBC_S_EXEC && opc[2] |=> ill_r && !irq_n)
      else $error("reserved opcode not trapped");
   a_wait_phase: assert property (
      @(posedge mclk) disable iff (!arst_n)
      s_two_words ##0 w0_r[SBC_F_WAIT] && legal && !ip_wr
      |=> st_r == SBC_S_WAIT)
      else $error("wait bit did not delay compare");
   a_loop_drive: assert property (
      @(posedge mclk) disable iff (!arst_n)
      loop_r ##1 loop_r |-> scsi_ctl_oe == $past(ocl_r))
      else $error("loopback latch not driven");
endmodule : sbc_sequencer

/* test/sbc_mem_model.sv */
/*
 * Instruction memory partner: answers held fetch requests with a
 * one-cycle ack, promptly or after a delay. Assumes the requester
 * holds mem_req and mem_addr until the ack.
 */
`timescale 1ns/1ps
module sbc_mem_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Fetch port
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   // Answer speed
   input wire logic slow
);
   logic [31:0] m [0:63]; // Word store, loaded by the bench
   logic [1:0] cnt_r; // Wait cycles spent on this request
   // Answer one word; data does not linger once ack is gone
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0;
         cnt_r <= 2'h0;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end else if (mem_req) begin
         // Slow answers wait three cycles
         if (!slow || cnt_r == 2'h3) begin
            mem_ack <= 1'b1;
            mem_rdata <= m[mem_addr[7:2]];
            cnt_r <= 2'h0;
         end else begin
            cnt_r <= cnt_r + 2'h1;
         end
      end
   end
endmodule : sbc_mem_model

/* test/test_scsi_branch_sequencer.sv */
/*
 * Bench for the branch sequencer: APB master, bus line driver and
 * instruction memory. Assumes the sbc_pkg constants and a 250 MHz mclk.
 */
`timescale 1ns/1ps
module test_scsi_branch_sequencer;
   import sbc_pkg::*;
   localparam logic [31:0] INTW = 32'h98000000; // Unconditional INT
   localparam logic [31:0] VT = 32'h7a7a0001; // Vector, taken path
   localparam logic [31:0] VF = 32'h5e5e0002; // Vector, fall path
   logic mclk, arst_n, psel, penable, pwrite, mem_ack, mem_req, pready;
   logic pslverr, irq_n, slow;
   logic [7:0] paddr, scsi_ctl_o, scsi_ctl_oe;
   logic [31:0] pwdata, prdata, mem_addr, mem_rdata, sv;
   sbc_bus_t bus; // Lines driven by the far bus device
   int errors, tests_run, cyc;
   sbc_sequencer uut (.mclk(mclk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .bus(bus), .scsi_ctl_o(scsi_ctl_o),
      .scsi_ctl_oe(scsi_ctl_oe), .irq_n(irq_n));
   sbc_mem_model mem (.mclk(mclk), .arst_n(arst_n), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .slow(slow));
   // Clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         conclude();
      end
   end
   task automatic conclude();
      if (errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask : chk
   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk) penable <= 1'b1;
      // Only the hang guard ends this wait
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq_n !== 1'b0 && n < 300) begin
         @(posedge mclk);
         n++;
      end
   endtask : wait_irq
   // Load a program, set the bus, start, and judge the path taken
   task automatic run_case(input logic [31:0] w0, input logic [31:0] w80,
      input logic [2:0] ph, input logic [7:0] dt, input logic at,
      input logic tg, input logic lt, input logic tk);
      logic [31:0] q;
      logic e;
      mem.m[16] = w0;
      mem.m[17] = 32'h80;
      mem.m[18] = INTW;
      mem.m[19] = VF;
      mem.m[32] = w80;
      mem.m[33] = VT;
      if (w0[29:27] == SBC_OP_CALL) sv = 32'h48;
      slow <= ~slow;
      bus.phase <= lt ? 3'h7 : ph;
      bus.data <= dt;
      bus.atn <= at;
      bus.req <= 1'b0;
      apb(1'b1, SBC_OFS_CTL0, {31'h0, tg}, q, e);
      bus.req <= 1'b1; // Phase settled before REQ rises
      apb(1'b1, SBC_OFS_IP, 32'h40, q, e); // Start
      if (lt) begin
         repeat (30) @(posedge mclk);
         bus.phase <= ph;
         bus.req <= 1'b0;
         @(posedge mclk);
         bus.req <= 1'b1;
      end
      wait_irq();
      chk(32'(irq_n), 32'h0);
      repeat (8) @(posedge mclk);
      chk(32'(mem_req), 32'h0);
      apb(1'b0, SBC_OFS_NEXT, 32'h0, q, e);
      chk(q, tk ? VT : VF);
      apb(1'b0, SBC_OFS_IP, 32'h0, q, e);
      chk(q, tk ? 32'h88 : 32'h50);
      apb(1'b0, SBC_OFS_SAVED, 32'h0, q, e);
      chk(q, sv);
   endtask : run_case
   // Illegal opcodes, status flag and interrupt clear
   task automatic illegal_ops();
      logic [31:0] q;
      logic e;
      for (int op = 4; op < 8; op++) begin
         mem.m[16] = 32'h80000000 | (32'(op) << 27);
         apb(1'b1, SBC_OFS_IP, 32'h40, q, e);
         wait_irq();
         apb(1'b0, SBC_OFS_STAT, 32'h0, q, e);
         chk(32'(q[SBC_ST_ILL]), 32'h1);
         apb(1'b1, SBC_OFS_STAT, 32'h6, q, e);
         chk(32'(irq_n), 32'h1);
      end
   endtask : illegal_ops
   // Loopback drive of the control lines and a refused address
   task automatic loop_and_map();
      logic [31:0] q;
      logic e;
      apb(1'b1, SBC_OFS_LOOP, 32'h1, q, e);
      apb(1'b1, SBC_OFS_OCL, 32'ha3, q, e);
      // Line drivers follow the latch one edge later
      @(posedge mclk);
      chk(32'(scsi_ctl_o), 32'ha3);
      chk(32'(scsi_ctl_oe), 32'ha3);
      // Poll the control line view: REQ left high, rest idle
      apb(1'b0, SBC_OFS_BCL, 32'h0, q, e);
      chk(q, 32'h80);
      apb(1'b1, SBC_OFS_LOOP, 32'h0, q, e);
      @(posedge mclk);
      chk(32'(scsi_ctl_oe), 32'h0);
      apb(1'b0, 8'h40, 32'h0, q, e);
      chk({q[30:0], e}, 32'h1);
   endtask : loop_and_map
   initial begin
      logic [2:0] codes [6];
      logic [31:0] q;
      logic e;
      codes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
      {arst_n, psel, penable, pwrite, slow} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      bus = '0;
      sv = 32'h0;
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (20) @(posedge mclk);
      chk(32'(mem_req), 32'h0);
      chk(32'(irq_n), 32'h1);
      apb(1'b0, SBC_OFS_IP, 32'h0, q, e);
      chk(q, SBC_IP_RST);
      foreach (codes[i])
         run_case(32'h800a0000 | (32'(codes[i]) << 24), INTW, codes[i],
            8'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      run_case(32'h830a0000, INTW, 3'h7, 8'h0, 0, 0, 0, 0);
      run_case(32'h83020000, INTW, 3'h7, 8'h0, 0, 0, 0, 1);
      run_case(32'h800c00a5, INTW, 3'h0, 8'ha5, 0, 0, 0, 1);
      run_case(32'h830e00a5, INTW, 3'h3, 8'h5a, 0, 0, 0, 0);
      run_case(32'h830600a5, INTW, 3'h6, 8'h5a, 0, 0, 0, 1);
      run_case(32'h800a0000, INTW, 3'h0, 8'h0, 1, 1, 0, 1);
      run_case(32'h831b0000, INTW, 3'h3, 8'h0, 0, 0, 1, 1);
      run_case(32'h9b0a0000, INTW, 3'h7, 8'h0, 0, 0, 0, 0);
      run_case(32'h88000000, 32'h90000000, 3'h0, 8'h0, 0, 0, 0, 0);
      illegal_ops();
      loop_and_map();
      conclude();
   end
endmodule : test_scsi_branch_sequencer
